/* root_sum_pkg.sv */
// Constants, register map and encodings of the root and block-sum unit.
package root_sum_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] FIRST_SOURCE_OFFSET = 8'h04;
  localparam logic [7:0] SECOND_SOURCE_OFFSET = 8'h08;
  localparam logic [7:0] RESULT_DEST_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam int CTRL_OP_BIT = 0;
  localparam int CTRL_TYPE_LSB = 1;
  localparam int CTRL_MODE_BIT = 4;
  localparam int CTRL_KIND_LSB = 5;
  localparam int CTRL_CONST_BIT = 7;
  localparam int STATUS_ERR_BIT = 0;
  localparam int STATUS_CARRY_BIT = 1;
  localparam int STATUS_BUSY_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Data memory layout and arithmetic constants
  // ----------------------------------------------------------------
  localparam logic [15:0] DREG_BASE = 16'h0000;
  localparam logic [17:0] DREG_COUNT = 18'h00800;
  localparam logic [15:0] TIMER_BASE = 16'h8000;
  localparam logic [17:0] TIMER_COUNT = 18'h00100;
  localparam logic [15:0] COUNTER_BASE = 16'hc000;
  localparam logic [17:0] COUNTER_COUNT = 18'h00100;
  localparam logic [49:0] SCALE_SQ = 50'h0_0000_0000_2710;
  localparam logic [4:0] SQRT_LAST = 5'h18;
  localparam logic signed [9:0] FLT_SHIFT = 10'sh096;
  localparam logic signed [9:0] FLT_ROOT_BIAS = 10'sh08a;
  localparam logic [31:0] FLT_MAX_MAG = 32'h7f7f_ffff;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    T_WORD = 3'b000,
    T_INT = 3'b001,
    T_DWORD = 3'b010,
    T_LONG = 3'b011,
    T_FLOAT = 3'b100
  } dtype_e;

  typedef enum logic [1:0] {
    K_DATA = 2'b00,
    K_TIMER = 2'b01,
    K_COUNTER = 2'b10
  } kind_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_FETCH = 4'b0001,
    S_WAIT = 4'b0010,
    S_CATCH = 4'b0011,
    S_COUNT = 4'b0100,
    S_ACCUM = 4'b0101,
    S_PREP = 4'b0110,
    S_SQRT = 4'b0111,
    S_PACK = 4'b1000,
    S_WRITE = 4'b1001,
    S_FINISH = 4'b1010
  } state_e;

endpackage

/* root_sum_unit.sv */
// Root and block-sum execution unit with AXI4-Lite control registers.
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module root_sum_unit import root_sum_pkg::*; (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Instruction sequencer.
  input wire logic exec_input,
  input wire logic scan_pulse,
  output logic exec_done,
  output logic exec_busy,
  // Special flags and lamp.
  output logic exec_error_flag,
  output logic carry_borrow_flag,
  output logic error_lamp,
  // Word data memory.
  output logic [15:0] mem_addr,
  output logic mem_rd_en,
  output logic mem_wr_en,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  // AXI4-Lite slave.
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] first_source;
  logic [15:0] second_source;
  logic [15:0] result_dest;
  logic aw_hold;
  logic w_hold;
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic err_clear;
  state_e state;
  state_e after;
  logic is_sum;
  logic is_xor;
  dtype_e dt;
  kind_e kind;
  logic fail;
  logic fetch_two;
  logic word_idx;
  logic [15:0] rd_ptr;
  logic [31:0] opnd;
  logic [15:0] remaining;
  logic [47:0] acc;
  logic [31:0] facc;
  logic fflag;
  logic [49:0] rad;
  logic [26:0] rem;
  logic [24:0] root;
  logic [4:0] step;
  logic signed [9:0] fexp;
  logic [31:0] res;
  logic more;
  logic carry_upd;
  logic carry_val;
  logic [15:0] src_base;
  logic [17:0] src_lim;
  logic [17:0] blk_end;
  logic [26:0] trial;
  logic [26:0] rem_sh;
  logic signed [9:0] f_eraw;
  logic signed [9:0] f_eadj;
  logic f_bad;
  logic [33:0] fsum;
  logic signed [9:0] pexp;
  dtype_e ctl_dt;
  kind_e ctl_kind;
  logic start_bad;

  // Floating add with truncation; returns {overflow, underflow, sum}.
  function automatic logic [33:0] float_add(input logic [31:0] a,
                                            input logic [31:0] b);
    logic [31:0] big;
    logic [31:0] sml;
    logic [27:0] mb;
    logic [27:0] ms;
    logic [27:0] s;
    logic [7:0] d;
    logic signed [9:0] e;
    logic [31:0] r;
    logic ovf;
    logic unf;
    big = (a[30:0] >= b[30:0]) ? a : b;
    sml = (a[30:0] >= b[30:0]) ? b : a;
    mb = {1'b0, |big[30:23], big[22:0], 3'h0};
    ms = {1'b0, |sml[30:23], sml[22:0], 3'h0};
    d = big[30:23] - sml[30:23];
    ms = (d > 8'h1b) ? 28'h0 : ms >> d;
    s = (big[31] == sml[31]) ? mb + ms : mb - ms;
    e = $signed({2'h0, big[30:23]});
    ovf = 1'b0;
    unf = 1'b0;
    r = 32'h0;
    if (s != 28'h0) begin
      if (s[27]) begin
        s = s >> 1;
        e = e + 10'sh001;
      end
      for (int i = 0; i < 26; i++) begin
        if (!s[26]) begin
          s = s << 1;
          e = e - 10'sh001;
        end
      end
      if (e >= 10'sh0ff) begin
        ovf = 1'b1;
        r = {big[31], FLT_MAX_MAG[30:0]};
      end else if (e <= 10'sh000) begin
        unf = 1'b1;
      end else begin
        r = {big[31], e[7:0], s[25:3]};
      end
    end
    return {ovf, unf, r};
  endfunction

  // Merges a write into an old register value under byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_fire = aw_hold && w_hold && !bvalid;
  assign err_clear = wr_fire && aw_addr_q == STATUS_OFFSET &&
                     w_strb_q[0] && w_data_q[STATUS_ERR_BIT];

  // Takes write address and data in either order, then answers.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        aw_addr_q <= awaddr;
        awready <= 1'b0;
      end else if (!aw_hold && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready <= 1'b0;
      end else if (!w_hold && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        unique case (aw_addr_q)
          CTRL_OFFSET, FIRST_SOURCE_OFFSET, SECOND_SOURCE_OFFSET,
          RESULT_DEST_OFFSET, STATUS_OFFSET: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Software-written configuration registers.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      first_source <= ADDR_RESET;
      second_source <= ADDR_RESET;
      result_dest <= ADDR_RESET;
    end else if (wr_fire) begin
      unique case (aw_addr_q)
        CTRL_OFFSET: ctrl <= merge(ctrl, w_data_q, w_strb_q);
        FIRST_SOURCE_OFFSET: first_source <= 16'(merge({16'h0,
          first_source}, w_data_q, w_strb_q));
        SECOND_SOURCE_OFFSET: second_source <= 16'(merge({16'h0,
          second_source}, w_data_q, w_strb_q));
        RESULT_DEST_OFFSET: result_dest <= 16'(merge({16'h0,
          result_dest}, w_data_q, w_strb_q));
        default: ;
      endcase
    end
  end

  // Read channel; unmapped addresses read zero with an error response.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      unique case (araddr)
        CTRL_OFFSET: rdata <= ctrl;
        FIRST_SOURCE_OFFSET: rdata <= {16'h0, first_source};
        SECOND_SOURCE_OFFSET: rdata <= {16'h0, second_source};
        RESULT_DEST_OFFSET: rdata <= {16'h0, result_dest};
        STATUS_OFFSET: rdata <= {29'h0, exec_busy, carry_borrow_flag,
                                 exec_error_flag};
        default: begin
          rdata <= 32'h0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Operand helpers
  // ----------------------------------------------------------------
  assign ctl_dt = dtype_e'(ctrl[CTRL_TYPE_LSB +: 3]);
  assign ctl_kind = kind_e'(ctrl[CTRL_KIND_LSB +: 2]);

  // Rejects type, mode and source combinations the unit cannot run.
  always_comb begin
    start_bad = 1'b0;
    if (!ctrl[CTRL_OP_BIT]) begin
      start_bad = !(ctl_dt == T_WORD || ctl_dt == T_DWORD ||
                    ctl_dt == T_FLOAT);
    end else if (ctrl[CTRL_MODE_BIT]) begin
      start_bad = ctl_dt != T_WORD;
    end else begin
      start_bad = ctrl[CTRL_TYPE_LSB +: 3] > 3'(T_FLOAT);
    end
    if (ctrl[CTRL_OP_BIT] && ctl_dt == T_FLOAT && ctl_kind != K_DATA) begin
      start_bad = 1'b1;
    end
    if (ctrl[CTRL_KIND_LSB +: 2] == 2'h3) begin
      start_bad = 1'b1;
    end
  end

  // Timers and counters are read from their current-value areas.
  always_comb begin
    unique case (kind)
      K_TIMER: begin
        src_base = TIMER_BASE;
        src_lim = TIMER_COUNT;
      end
      K_COUNTER: begin
        src_base = COUNTER_BASE;
        src_lim = COUNTER_COUNT;
      end
      default: begin
        src_base = DREG_BASE;
        src_lim = DREG_COUNT;
      end
    endcase
  end

  assign blk_end = {2'h0, first_source} +
                   ({2'h0, opnd[15:0]} << (dt != T_WORD && dt != T_INT));
  assign rem_sh = {rem[24:0], rad[49:48]};
  assign trial = {root, 2'b01};
  assign f_eraw = $signed({2'h0, opnd[30:23]}) - FLT_SHIFT;
  assign f_eadj = f_eraw[0] ? f_eraw - 10'sh001 : f_eraw;
  assign f_bad = opnd[30:23] == 8'hff ||
                 (opnd[30:23] == 8'h00 && opnd[22:0] != 23'h0);
  assign fsum = float_add(facc, opnd);
  assign pexp = root[24] ? fexp + 10'sh001 : fexp;

  // ----------------------------------------------------------------
  // Execution sequencer
  // ----------------------------------------------------------------
  // One pass per scan pulse; finishes well inside a scan.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= S_IDLE;
      after <= S_IDLE;
      is_sum <= 1'b0;
      is_xor <= 1'b0;
      dt <= T_WORD;
      kind <= K_DATA;
      fail <= 1'b0;
      fetch_two <= 1'b0;
      word_idx <= 1'b0;
      rd_ptr <= 16'h0;
      opnd <= 32'h0;
      remaining <= 16'h0;
      acc <= 48'h0;
      facc <= 32'h0;
      fflag <= 1'b0;
      rad <= 50'h0;
      rem <= 27'h0;
      root <= 25'h0;
      step <= 5'h0;
      fexp <= 10'sh000;
      res <= 32'h0;
      more <= 1'b0;
      carry_upd <= 1'b0;
      carry_val <= 1'b0;
      mem_addr <= 16'h0;
      mem_rd_en <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_wdata <= 16'h0;
      exec_done <= 1'b0;
    end else begin
      exec_done <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (scan_pulse && exec_input) begin
            is_sum <= ctrl[CTRL_OP_BIT];
            is_xor <= ctrl[CTRL_MODE_BIT];
            dt <= ctl_dt;
            kind <= ctl_kind;
            fail <= start_bad;
            carry_upd <= 1'b0;
            acc <= 48'h0;
            facc <= 32'h0;
            fflag <= 1'b0;
            word_idx <= 1'b0;
            if (start_bad) begin
              state <= S_FINISH;
            end else if (!ctrl[CTRL_OP_BIT]) begin
              rd_ptr <= DREG_BASE + first_source;
              fetch_two <= ctl_dt != T_WORD;
              after <= S_PREP;
              state <= S_FETCH;
            end else if (ctrl[CTRL_CONST_BIT]) begin
              opnd <= {16'h0, second_source};
              state <= S_COUNT;
            end else begin
              rd_ptr <= DREG_BASE + second_source;
              fetch_two <= 1'b0;
              after <= S_COUNT;
              state <= S_FETCH;
            end
          end
        end
        S_FETCH: begin
          mem_addr <= rd_ptr;
          mem_rd_en <= 1'b1;
          state <= S_WAIT;
        end
        S_WAIT: begin
          mem_rd_en <= 1'b0;
          state <= S_CATCH;
        end
        S_CATCH: begin
          opnd <= {opnd[15:0], mem_rdata};
          rd_ptr <= rd_ptr + 16'h1;
          if (fetch_two && !word_idx) begin
            word_idx <= 1'b1;
            state <= S_FETCH;
          end else begin
            word_idx <= 1'b0;
            state <= after;
          end
        end
        S_COUNT: begin
          if (opnd[15:0] == 16'h0 || blk_end > src_lim) begin
            fail <= 1'b1;
            state <= S_FINISH;
          end else begin
            remaining <= opnd[15:0];
            rd_ptr <= src_base + first_source;
            fetch_two <= dt != T_WORD && dt != T_INT;
            after <= S_ACCUM;
            state <= S_FETCH;
          end
        end
        S_ACCUM: begin
          remaining <= remaining - 16'h1;
          state <= (remaining == 16'h1) ? S_PACK : S_FETCH;
          if (is_xor) begin
            acc[15:0] <= acc[15:0] ^ opnd[15:0];
          end else begin
            unique case (dt)
              T_WORD: acc <= acc + {32'h0, opnd[15:0]};
              T_INT: acc <= acc + {{32{opnd[15]}}, opnd[15:0]};
              T_DWORD: acc <= acc + {16'h0, opnd};
              T_LONG: acc <= acc + {{16{opnd[31]}}, opnd};
              default: begin
                if (f_bad) begin
                  fail <= 1'b1;
                  state <= S_FINISH;
                end else begin
                  facc <= fsum[31:0];
                  fflag <= fflag | fsum[33] | fsum[32];
                end
              end
            endcase
          end
        end
        S_PREP: begin
          rem <= 27'h0;
          root <= 25'h0;
          step <= 5'h0;
          state <= S_SQRT;
          if (dt == T_WORD) begin
            rad <= {34'h0, opnd[15:0]} * SCALE_SQ;
          end else if (dt == T_DWORD) begin
            rad <= {18'h0, opnd} * SCALE_SQ;
          end else if (f_bad) begin
            fail <= 1'b1;
            state <= S_FINISH;
          end else if (opnd[31] && opnd[30:0] != 31'h0) begin
            fail <= 1'b1;
            state <= S_FINISH;
          end else if (opnd[30:0] == 31'h0) begin
            rad <= 50'h0;
          end else begin
            rad <= f_eraw[0] ? {1'b0, 1'b1, opnd[22:0], 25'h0}
                             : {2'h0, 1'b1, opnd[22:0], 24'h0};
            fexp <= (f_eadj >>> 1) + FLT_ROOT_BIAS;
          end
        end
        S_SQRT: begin
          rad <= rad << 2;
          step <= step + 5'h1;
          if (rem_sh >= trial) begin
            rem <= rem_sh - trial;
            root <= {root[23:0], 1'b1};
          end else begin
            rem <= rem_sh;
            root <= {root[23:0], 1'b0};
          end
          if (step == SQRT_LAST) begin
            state <= S_PACK;
          end
        end
        S_PACK: begin
          mem_addr <= DREG_BASE + result_dest - 16'h1;
          state <= S_WRITE;
          carry_upd <= 1'b0;
          carry_val <= 1'b0;
          more <= 1'b1;
          if (!is_sum) begin
            carry_upd <= dt != T_WORD;
            if (dt == T_WORD) begin
              res <= {root[15:0], 16'h0};
              more <= 1'b0;
            end else if (dt == T_DWORD) begin
              res <= {7'h0, root};
            end else if (root == 25'h0) begin
              res <= 32'h0;
            end else begin
              res <= {1'b0, pexp[7:0],
                      root[24] ? root[23:1] : root[22:0]};
            end
          end else if (is_xor) begin
            res <= {acc[15:0], 16'h0};
            more <= 1'b0;
          end else begin
            carry_upd <= dt != T_WORD && dt != T_INT;
            unique case (dt)
              T_WORD, T_INT: res <= acc[31:0];
              T_DWORD: begin
                res <= acc[31:0];
                carry_val <= acc[47:32] != 16'h0;
              end
              T_LONG: begin
                res <= acc[31:0];
                carry_val <= acc[47:31] != {17{acc[31]}};
              end
              default: begin
                res <= facc;
                carry_val <= fflag;
              end
            endcase
          end
        end
        S_WRITE: begin
          mem_addr <= mem_addr + 16'h1;
          mem_wdata <= res[31:16];
          mem_wr_en <= 1'b1;
          res <= {res[15:0], 16'h0};
          more <= 1'b0;
          if (!more) begin
            state <= S_FINISH;
          end
        end
        S_FINISH: begin
          mem_wr_en <= 1'b0;
          exec_done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flags and status outputs
  // ----------------------------------------------------------------
  // Error flag and lamp latch; a new error wins over a software clear.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      exec_error_flag <= 1'b0;
      error_lamp <= 1'b0;
    end else if (state == S_FINISH && fail) begin
      exec_error_flag <= 1'b1;
      error_lamp <= 1'b1;
    end else if (err_clear) begin
      exec_error_flag <= 1'b0;
      error_lamp <= 1'b0;
    end
  end

  // Carry follows each successful 32-bit or float execution.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      carry_borrow_flag <= 1'b0;
    end else if (state == S_FINISH && !fail && carry_upd) begin
      carry_borrow_flag <= carry_val;
    end
  end

  // Busy flag for software and the sequencer.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      exec_busy <= 1'b0;
    end else begin
      exec_busy <= !(state == S_FINISH ||
                     (state == S_IDLE && !(scan_pulse && exec_input)));
    end
  end

endmodule

/* root_sum_unit_monitor.sv */
// Checker of the root and block-sum unit at its top-level ports.
`timescale 1ns/1ps
module root_sum_monitor (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Sequencer, flags, memory strobes and write channel.
  input wire logic exec_input,
  input wire logic scan_pulse,
  input wire logic exec_done,
  input wire logic exec_busy,
  input wire logic exec_error_flag,
  input wire logic error_lamp,
  input wire logic mem_rd_en,
  input wire logic mem_wr_en,
  input wire logic bvalid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A start request that the idle unit must take.
  sequence take_s;
    scan_pulse && exec_input && !exec_busy;
  endsequence
  // One done pulse, after which the unit is idle again.
  sequence end_s;
    exec_done ##1 (!exec_done && !exec_busy);
  endsequence
  lamp_follows_a: assert property (error_lamp == exec_error_flag)
    else $error("lamp differs from error flag");
  start_taken_a: assert property (take_s |=> exec_busy)
    else $error("start request not taken");
  finish_bound_a: assert property (take_s |-> ##[1:400] exec_done)
    else $error("execution did not finish");
  done_ends_a: assert property (exec_done |-> end_s)
    else $error("done not a single pulse ending busy");
  err_sticky_a: assert property (exec_error_flag |=>
    exec_error_flag || $rose(bvalid))
    else $error("error flag dropped without clear");
  idle_quiet_a: assert property (
    !exec_busy |-> !mem_wr_en && !mem_rd_en)
    else $error("memory access outside execution");
  rd_pulse_a: assert property (mem_rd_en |=> !mem_rd_en)
    else $error("read strobe longer than one cycle");
  wr_burst_a: assert property (
    mem_wr_en ##1 mem_wr_en |=> !mem_wr_en)
    else $error("more than two words written");
  err_no_wr_a: assert property ($rose(exec_error_flag) |->
    exec_done && !$past(mem_wr_en))
    else $error("error raised off done or after a write");
endmodule

bind root_sum_unit root_sum_monitor chk_u (.clock, .rst_n, .exec_input,
  .scan_pulse, .exec_done, .exec_busy, .exec_error_flag, .error_lamp,
  .mem_rd_en, .mem_wr_en, .bvalid);

/* word_mem_model.sv */
// Word data memory model answering the unit's reads and writes.
`timescale 1ns/1ps
module word_mem_model (
  // Clock.
  input wire logic clock,
  // Access port from the unit.
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd_en,
  input wire logic mem_wr_en,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:65535];
  // Read data holds only in the cycle after the strobe; otherwise the
  // bus inverts each cycle, so a stale word reads inverted one cycle late and true again two cycles late.
  always @(posedge clock) begin
    if (mem_rd_en) begin
      mem_rdata <= mem[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr_en) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

/* root_and_block_sum_unit_tb.sv */
// Self-checking bench of the root and block-sum unit.
`timescale 1ns/1ps
module root_and_block_sum_unit_tb import root_sum_pkg::*; ;
  logic clock, exec_done, exec_busy, exec_error_flag, carry_borrow_flag;
  logic error_lamp, mem_rd_en, mem_wr_en, awready, wready, bvalid;
  logic arready, rvalid;
  logic rst_n = 0, exec_input = 0, scan_pulse = 0, awvalid = 0;
  logic wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [31:0] wdata = '0, rdata, rd_v;
  logic [1:0] bresp, rresp, lr;
  int err_count, n_checks, cyc;
  root_sum_unit DUT (.clock, .rst_n, .exec_input, .scan_pulse, .exec_done,
    .exec_busy, .exec_error_flag, .carry_borrow_flag, .error_lamp,
    .mem_addr, .mem_rd_en, .mem_wr_en, .mem_wdata, .mem_rdata, .awaddr,
    .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  word_mem_model mem_u (.clock, .mem_addr, .mem_rd_en, .mem_wr_en,
    .mem_wdata, .mem_rdata);
  // Free-running 50 MHz clock.
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Bus write; both channels offered together, each released when taken.
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clock); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge clock); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge clock); while (!bvalid);
    lr = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    rd_v = rdata;
    lr = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask
  // One scan pulse with the input held on, then wait for the flags.
  task go;
    exec_input <= 1'b1;
    scan_pulse <= 1'b1;
    @(posedge clock);
    scan_pulse <= 1'b0;
    do @(posedge clock); while (!exec_done);
    repeat (2) @(posedge clock);
  endtask
  task run(input logic [7:0] c, input logic [15:0] s, n, d);
    wr(CTRL_OFFSET, {24'h0, c});
    wr(FIRST_SOURCE_OFFSET, {16'h0, s});
    wr(SECOND_SOURCE_OFFSET, {16'h0, n});
    wr(RESULT_DEST_OFFSET, {16'h0, d});
    go;
  endtask
  // Word root, then a second scan on a changed source.
  task t_word_root;
    mem_u.mem[16'h10] = 16'h0002;
    run(8'h00, 16'h0010, 16'h0000, 16'h0020);
    chk(mem_u.mem[16'h20], 32'h008d);
    mem_u.mem[16'h10] = 16'h0004;
    go;
    chk(mem_u.mem[16'h20], 32'h00c8);
  endtask
  // Word add and word XOR over four words, then a timer-sourced add.
  task t_sums;
    mem_u.mem[0] = 16'h0105;
    mem_u.mem[1] = 16'h02f6;
    mem_u.mem[2] = 16'h0307;
    mem_u.mem[3] = 16'h0408;
    mem_u.mem[16'h50] = 16'h0004;
    mem_u.mem[16'h111] = 16'hbeef;
    run(8'h81, 16'h0000, 16'h0004, 16'h0100);
    chk({mem_u.mem[16'h100], mem_u.mem[16'h101]}, 32'h0b0a);
    run(8'h11, 16'h0000, 16'h0050, 16'h0110);
    chk(mem_u.mem[16'h110], 32'h04fc);
    chk(mem_u.mem[16'h111], 32'hbeef);
    mem_u.mem[16'h8000] = 16'h3f80;
    run(8'ha1, 16'h0000, 16'h0001, 16'h0140);
    chk(mem_u.mem[16'h141], 32'h3f80);
  endtask
  // Carry on 32-bit overflow, cleared by an in-range root.
  task t_carry;
    mem_u.mem[16'h200] = 16'hffff;
    mem_u.mem[16'h201] = 16'hffff;
    mem_u.mem[16'h202] = 16'h0000;
    mem_u.mem[16'h203] = 16'h0001;
    run(8'h85, 16'h0200, 16'h0002, 16'h0300);
    chk(carry_borrow_flag, 1'b1);
    mem_u.mem[16'h30] = 16'h0001;
    mem_u.mem[16'h31] = 16'h0000;
    run(8'h04, 16'h0030, 16'h0000, 16'h0040);
    chk({mem_u.mem[16'h40], mem_u.mem[16'h41]}, 32'h6400);
    chk(carry_borrow_flag, 1'b0);
    mem_u.mem[16'h200] = 16'h7fff;
    run(8'h87, 16'h0200, 16'h0002, 16'h0300);
    chk(carry_borrow_flag, 1'b1);
  endtask
  // Each refused case raises the flag and lamp; software clears them.
  task t_errors;
    logic [7:0] c [7] = '{8'h81, 8'h08, 8'h08, 8'h93, 8'h02, 8'h81, 8'ha9};
    logic [15:0] s [7] = '{16'h0, 16'h60, 16'h62, 16'h0, 16'h10, 16'h0,
      16'h0};
    logic [15:0] n [7] = '{16'h0, 16'h0, 16'h0, 16'h4, 16'h0, 16'h801,
      16'h1};
    mem_u.mem[16'h60] = 16'hbf80;
    mem_u.mem[16'h61] = 16'h0000;
    mem_u.mem[16'h62] = 16'h0000;
    mem_u.mem[16'h63] = 16'h0001;
    for (int i = 0; i < 7; i++) begin
      run(c[i], s[i], n[i], 16'h0120);
      chk(exec_error_flag, 1'b1);
      chk(error_lamp, 1'b1);
      wr(STATUS_OFFSET, 32'h1);
      chk(exec_error_flag, 1'b0);
    end
  endtask
  // The flag stays up while later executions still complete.
  task t_sticky;
    run(8'h81, 16'h0000, 16'h0000, 16'h0120);
    run(8'h00, 16'h0010, 16'h0000, 16'h0130);
    chk(mem_u.mem[16'h130], 32'h00c8);
    rd(STATUS_OFFSET);
    chk(rd_v[0], 1'b1);
    wr(8'h20, 32'h1);
    chk(lr, RESP_SLVERR);
    rd(8'h24);
    chk(lr, RESP_SLVERR);
    chk(rd_v, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_word_root;
    t_sums;
    t_carry;
    t_errors;
    t_sticky;
    conclude;
  end
endmodule
